// ==== hdl/autoneg_partner_nextpage_regs.sv ====
// Partner ability, expansion status and local next-page registers on an Avalon-MM slave.
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module autoneg_partner_nextpage_regs
(
   input  wire logic                                      i_clk,
   input  wire logic                                      i_rst_n,
   input  wire logic [autoneg_regs_pkg::ADDR_W-1:0]       i_address,
   input  wire logic                                      i_read,
   input  wire logic                                      i_write,
   input  wire logic [autoneg_regs_pkg::DATA_W-1:0]       i_writedata,
   input  wire logic [3:0]                                i_byteenable,
   output logic      [autoneg_regs_pkg::DATA_W-1:0]       o_readdata,
   output logic                                           o_waitrequest,
   input  wire logic                                      i_lcw_valid,
   input  wire logic                                      i_lcw_base,
   input  wire logic [autoneg_regs_pkg::REG_W-1:0]        i_lcw_word,
   input  wire logic                                      i_np_sent,
   input  wire logic                                      i_an_restart,
   input  wire logic                                      i_pd_fault_async,
   output logic      [autoneg_regs_pkg::REG_W-1:0]        o_local_next_page
);
   typedef struct packed
   {
      logic [autoneg_regs_pkg::REG_W-1:0]  partner;
      logic                                lp_np_able;
      logic                                lp_an_able;
      logic [autoneg_regs_pkg::REG_W-1:0]  next_page;
      logic [autoneg_regs_pkg::DATA_W-1:0] rdata;
      logic                                wait_req;
   } regs_state_t;

   regs_state_t state_q;
   regs_state_t state_d;

   logic [autoneg_regs_pkg::IDX_W-1:0] idx;
   logic                               take;
   logic                               rd_take;
   logic                               wr_take;
   logic                               exp_read;
   logic                               np_write;
   logic                               pd_fault_lvl;
   logic                               pd_fault_flag;
   logic                               page_rcvd_flag;
   logic                               base_rcvd;
   logic [autoneg_regs_pkg::REG_W-1:0] exp_word;
   logic [autoneg_regs_pkg::REG_W-1:0] lane_mask;
   logic [autoneg_regs_pkg::REG_W-1:0] np_mask;
   logic [autoneg_regs_pkg::REG_W-1:0] rd_word;

   // The fault indication comes from the analog detection path, so it is resynchronised.
   level_sync2 pd_sync
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_async (i_pd_fault_async),
      .o_level (pd_fault_lvl)
   );

   sticky_flag pd_fault_latch
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_set   (pd_fault_lvl),
      .i_clear (exp_read),
      .o_flag  (pd_fault_flag)
   );

   sticky_flag page_rcvd_latch
   (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_set   (i_lcw_valid),
      .i_clear (exp_read),
      .o_flag  (page_rcvd_flag)
   );

   // A request is taken in the cycle it is seen while waitrequest is still high.
   assign idx       = i_address[autoneg_regs_pkg::ADDR_W-1:2];
   assign take      = state_q.wait_req & (i_read | i_write);
   assign rd_take   = take & i_read;
   assign wr_take   = take & i_write & ~i_read;
   assign exp_read  = rd_take & (idx == autoneg_regs_pkg::IDX_EXPAND);
   assign np_write  = wr_take & (idx == autoneg_regs_pkg::IDX_NEXTPG);
   assign base_rcvd = i_lcw_valid & i_lcw_base;
   assign lane_mask = {{8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
   assign np_mask   = lane_mask & autoneg_regs_pkg::NP_WR_MASK;

   always_comb
   begin
      exp_word                                         = '0;
      exp_word[autoneg_regs_pkg::EX_PD_FAULT]          = pd_fault_flag;
      exp_word[autoneg_regs_pkg::EX_LP_NP_ABLE]        = state_q.lp_np_able;
      exp_word[autoneg_regs_pkg::EX_LOC_NP_ABLE]       = autoneg_regs_pkg::LOCAL_NP_ABLE;
      exp_word[autoneg_regs_pkg::EX_PAGE_RCVD]         = page_rcvd_flag;
      exp_word[autoneg_regs_pkg::EX_LP_AN_ABLE]        = state_q.lp_an_able;
   end

   // Unmapped addresses read as zero and ignore writes.
   always_comb
   begin
      if (idx == autoneg_regs_pkg::IDX_PARTNER)
         rd_word = state_q.partner;
      else if (idx == autoneg_regs_pkg::IDX_EXPAND)
         rd_word = exp_word;
      else if (idx == autoneg_regs_pkg::IDX_NEXTPG)
         rd_word = state_q.next_page;
      else
         rd_word = '0;
   end

   always_comb
   begin
      state_d = state_q;

      // One cycle of low waitrequest answers each taken request.
      state_d.wait_req = ~take;
      if (rd_take)
         state_d.rdata = {{(autoneg_regs_pkg::DATA_W-autoneg_regs_pkg::REG_W){1'b0}}, rd_word};

      // A restart forgets the previous partner; a base page arriving in the same cycle wins.
      if (i_an_restart)
      begin
         state_d.partner    = '0;
         state_d.lp_np_able = 1'b0;
         state_d.lp_an_able = 1'b0;
      end
      if (base_rcvd)
      begin
         state_d.partner    = i_lcw_word & autoneg_regs_pkg::PB_KEEP_MASK;
         state_d.lp_np_able = i_lcw_word[autoneg_regs_pkg::PB_NEXT_PAGE];
         state_d.lp_an_able = 1'b1;
      end

      // Toggle is hardware owned, so software writes never reach it.
      if (np_write)
         state_d.next_page = (state_q.next_page & ~np_mask)
                           | (i_writedata[autoneg_regs_pkg::REG_W-1:0] & np_mask);
      if (i_an_restart)
         state_d.next_page[autoneg_regs_pkg::NP_TOGGLE] = 1'b0;
      else if (i_np_sent)
         state_d.next_page[autoneg_regs_pkg::NP_TOGGLE] =
            ~state_q.next_page[autoneg_regs_pkg::NP_TOGGLE];
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_q            <= '0;
         state_q.next_page  <= autoneg_regs_pkg::NP_RESET;
         state_q.wait_req   <= 1'b1;
      end
      else
         state_q <= state_d;
   end

   assign o_readdata        = state_q.rdata;
   assign o_waitrequest     = state_q.wait_req;
   assign o_local_next_page = state_q.next_page;

   // Checks of the register behaviour.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   sequence req_taken_s;
      (i_read || i_write) && o_waitrequest;
   endsequence

   sequence exp_read_s;
      i_read && o_waitrequest && (idx == autoneg_regs_pkg::IDX_EXPAND) && !i_lcw_valid && !pd_fault_lvl;
   endsequence

   sequence base_page_s;
      i_rst_n && i_lcw_valid && i_lcw_base;
   endsequence

   bus_answer_a: assert property (req_taken_s |=> !o_waitrequest ##1 o_waitrequest)
      else $error("waitrequest did not drop for exactly one cycle");

   partner_np_a: assert property (base_page_s |=>
      state_q.partner[autoneg_regs_pkg::PB_NEXT_PAGE] == $past(i_lcw_word[autoneg_regs_pkg::PB_NEXT_PAGE]))
      else $error("partner next page bit not loaded");

   partner_ack_a: assert property (base_page_s |=>
      state_q.partner[autoneg_regs_pkg::PB_ACK] == $past(i_lcw_word[autoneg_regs_pkg::PB_ACK]))
      else $error("partner acknowledge bit not loaded");

   partner_rfault_a: assert property (base_page_s |=>
      state_q.partner[autoneg_regs_pkg::PB_RFAULT] == $past(i_lcw_word[autoneg_regs_pkg::PB_RFAULT]))
      else $error("partner remote fault bit not loaded");

   partner_pause_a: assert property (base_page_s |=>
      state_q.partner[autoneg_regs_pkg::PB_ASYM:autoneg_regs_pkg::PB_PAUSE]
         == $past(i_lcw_word[autoneg_regs_pkg::PB_ASYM:autoneg_regs_pkg::PB_PAUSE]))
      else $error("partner pause bits not loaded");

   partner_tech_a: assert property (base_page_s |=>
      state_q.partner[autoneg_regs_pkg::PB_TECH_HI:autoneg_regs_pkg::PB_TECH_LO]
         == $past(i_lcw_word[autoneg_regs_pkg::PB_TECH_HI:autoneg_regs_pkg::PB_TECH_LO]))
      else $error("partner technology bits not loaded");

   selector_reset_a: assert property ($rose(i_rst_n) |->
      state_q.partner[autoneg_regs_pkg::PB_SEL_HI:autoneg_regs_pkg::PB_SEL_LO] == '0)
      else $error("partner selector not cleared by reset");

   pd_fault_latch_a: assert property (pd_fault_lvl |=> pd_fault_flag)
      else $error("parallel detection fault not latched");

   clear_on_read_a: assert property (exp_read_s |=> !pd_fault_flag && !page_rcvd_flag)
      else $error("latched flags not cleared by expansion read");

   flag_hold_a: assert property (i_rst_n && page_rcvd_flag && !exp_read |=> page_rcvd_flag)
      else $error("page received flag dropped without a read");

   lp_np_able_a: assert property (base_page_s |=>
      state_q.lp_np_able == $past(i_lcw_word[autoneg_regs_pkg::PB_NEXT_PAGE]))
      else $error("partner next page ability wrong");

   local_np_able_a: assert property (exp_read_s |=>
      o_readdata[autoneg_regs_pkg::EX_LOC_NP_ABLE] && !o_waitrequest)
      else $error("local next page ability did not read one");

   page_rcvd_a: assert property (i_lcw_valid |=> page_rcvd_flag)
      else $error("page received flag not set");

   lp_an_able_a: assert property (base_page_s |=> state_q.lp_an_able)
      else $error("partner negotiation ability not set");

   np_reset_a: assert property ($rose(i_rst_n) |->
      o_local_next_page == autoneg_regs_pkg::NP_RESET)
      else $error("next page register reset value wrong");

   np_write_a: assert property (np_write && (i_byteenable[1:0] == 2'h3) |=>
      (o_local_next_page & autoneg_regs_pkg::NP_WR_MASK)
         == ($past(i_writedata[autoneg_regs_pkg::REG_W-1:0]) & autoneg_regs_pkg::NP_WR_MASK))
      else $error("next page write not stored");

   toggle_flip_a: assert property (i_np_sent && !i_an_restart |=>
      o_local_next_page[autoneg_regs_pkg::NP_TOGGLE] != $past(o_local_next_page[autoneg_regs_pkg::NP_TOGGLE]))
      else $error("toggle did not invert after a sent page");

   toggle_hold_a: assert property (np_write && !i_np_sent && !i_an_restart |=>
      $stable(o_local_next_page[autoneg_regs_pkg::NP_TOGGLE]))
      else $error("software write changed the toggle bit");

   reserved_zero_a: assert property (state_q.partner[12] == 1'b0
      && o_local_next_page[14] == 1'b0)
      else $error("reserved bit read non-zero");

   ro_write_a: assert property (wr_take && (idx == autoneg_regs_pkg::IDX_PARTNER)
      && !i_lcw_valid && !i_an_restart |=> $stable(state_q.partner))
      else $error("write to read-only partner register took effect");

   // Checks that sample i_rst_n in their antecedent, as read_take_s does, skip an attempt that starts while reset is still sampled low: a reset held for
   // only one edge would otherwise clear state between antecedent and consequent.
   sequence read_take_s;
      i_rst_n && i_read && o_waitrequest;
   endsequence

   read_upper_zero_a: assert property (
      o_readdata[autoneg_regs_pkg::DATA_W-1:autoneg_regs_pkg::REG_W] == '0)
      else $error("upper read data bits not zero");

   wait_idle_a: assert property (o_waitrequest && !i_read && !i_write |=> o_waitrequest)
      else $error("waitrequest dropped without a request");

   wait_once_a: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low for more than one cycle");

   rdata_hold_a: assert property (i_rst_n && !rd_take |=> $stable(o_readdata))
      else $error("read data changed without a read");

   read_partner_a: assert property (read_take_s ##0 (idx == autoneg_regs_pkg::IDX_PARTNER) |=>
      o_readdata[autoneg_regs_pkg::REG_W-1:0] == $past(state_q.partner))
      else $error("partner register read wrong");

   read_expand_a: assert property (read_take_s ##0 (idx == autoneg_regs_pkg::IDX_EXPAND) |=>
      o_readdata[autoneg_regs_pkg::EX_PD_FAULT] == $past(pd_fault_flag)
      && o_readdata[autoneg_regs_pkg::EX_PAGE_RCVD] == $past(page_rcvd_flag))
      else $error("expansion flags read wrong");

   read_ability_a: assert property (read_take_s ##0 (idx == autoneg_regs_pkg::IDX_EXPAND) |=>
      o_readdata[autoneg_regs_pkg::EX_LP_NP_ABLE] == $past(state_q.lp_np_able)
      && o_readdata[autoneg_regs_pkg::EX_LP_AN_ABLE] == $past(state_q.lp_an_able))
      else $error("partner ability bits read wrong");

   exp_reserved_a: assert property (read_take_s ##0 (idx == autoneg_regs_pkg::IDX_EXPAND) |=>
      o_readdata[autoneg_regs_pkg::REG_W-1:autoneg_regs_pkg::EX_PD_FAULT+1] == '0)
      else $error("expansion reserved bits read non-zero");

   read_nextpg_a: assert property (read_take_s ##0 (idx == autoneg_regs_pkg::IDX_NEXTPG) |=>
      o_readdata[autoneg_regs_pkg::REG_W-1:0] == $past(state_q.next_page))
      else $error("next page register read wrong");

   read_unmapped_a: assert property (read_take_s ##0 (idx < autoneg_regs_pkg::IDX_PARTNER) |=>
      o_readdata == '0)
      else $error("unmapped address read non-zero");

   partner_sel_a: assert property (base_page_s |=>
      state_q.partner[autoneg_regs_pkg::PB_SEL_HI:autoneg_regs_pkg::PB_SEL_LO]
         == $past(i_lcw_word[autoneg_regs_pkg::PB_SEL_HI:autoneg_regs_pkg::PB_SEL_LO]))
      else $error("partner selector not loaded");

   partner_keep_a: assert property (i_rst_n && !i_lcw_valid && !i_an_restart |=>
      $stable(state_q.partner))
      else $error("partner register changed without a code word");

   nonbase_keep_a: assert property (i_rst_n && i_lcw_valid && !i_lcw_base && !i_an_restart |=>
      $stable(state_q.partner))
      else $error("next page code word changed partner register");

   ability_keep_a: assert property (i_rst_n && !base_rcvd && !i_an_restart |=>
      $stable(state_q.lp_np_able) && $stable(state_q.lp_an_able))
      else $error("partner ability changed without a base page");

   restart_clear_a: assert property (i_an_restart && !i_lcw_valid |=>
      state_q.partner == '0 && !state_q.lp_np_able && !state_q.lp_an_able)
      else $error("restart did not clear partner state");

   restart_toggle_a: assert property (i_an_restart |=>
      !o_local_next_page[autoneg_regs_pkg::NP_TOGGLE])
      else $error("restart did not clear toggle");

   toggle_quiet_a: assert property (i_rst_n && !i_np_sent && !i_an_restart |=>
      $stable(o_local_next_page[autoneg_regs_pkg::NP_TOGGLE]))
      else $error("toggle changed without an exchange");

   pd_hold_a: assert property (i_rst_n && pd_fault_flag && !exp_read |=> pd_fault_flag)
      else $error("fault flag dropped without a read");

   pd_set_wins_a: assert property (pd_fault_lvl && exp_read |=> pd_fault_flag)
      else $error("fault flag lost to a read in the same cycle");

   page_set_wins_a: assert property (i_lcw_valid && exp_read |=> page_rcvd_flag)
      else $error("page flag lost to a read in the same cycle");

   np_lane_off_a: assert property (i_rst_n && np_write && (i_byteenable[1:0] == 2'h0) |=>
      $stable(o_local_next_page & autoneg_regs_pkg::NP_WR_MASK))
      else $error("next page write without lanes took effect");

   exp_write_a: assert property (i_rst_n && wr_take && (idx == autoneg_regs_pkg::IDX_EXPAND)
      && !i_lcw_valid && !pd_fault_lvl |=> $stable(page_rcvd_flag) && $stable(pd_fault_flag))
      else $error("write to expansion register took effect");

   np_other_write_a: assert property (i_rst_n && wr_take && (idx != autoneg_regs_pkg::IDX_NEXTPG)
      && !i_np_sent && !i_an_restart |=> $stable(o_local_next_page))
      else $error("write elsewhere changed next page register");

endmodule

// ==== hdl/autoneg_regs_pkg.sv ====
// Constants for the auto-negotiation partner, expansion and next-page register group.
package autoneg_regs_pkg;

   localparam int ADDR_W = 5;
   localparam int IDX_W  = 3;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;

   // Word indices; byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_PARTNER = 3'h5;
   localparam logic [IDX_W-1:0] IDX_EXPAND  = 3'h6;
   localparam logic [IDX_W-1:0] IDX_NEXTPG  = 3'h7;

   // Partner base page ability fields.
   localparam int PB_NEXT_PAGE = 15;
   localparam int PB_ACK       = 14;
   localparam int PB_RFAULT    = 13;
   localparam int PB_ASYM      = 11;
   localparam int PB_PAUSE     = 10;
   localparam int PB_TECH_HI   = 9;
   localparam int PB_TECH_LO   = 5;
   localparam int PB_SEL_HI    = 4;
   localparam int PB_SEL_LO    = 0;
   localparam logic [REG_W-1:0] PB_KEEP_MASK = 16'hEFFF;

   // Expansion status fields.
   localparam int EX_PD_FAULT     = 4;
   localparam int EX_LP_NP_ABLE   = 3;
   localparam int EX_LOC_NP_ABLE  = 2;
   localparam int EX_PAGE_RCVD    = 1;
   localparam int EX_LP_AN_ABLE   = 0;
   localparam logic LOCAL_NP_ABLE = 1'b1;

   // Local next page transmit fields.
   localparam int NP_NEXT_PAGE = 15;
   localparam int NP_MSG_PAGE  = 13;
   localparam int NP_ACK2      = 12;
   localparam int NP_TOGGLE    = 11;
   localparam int NP_CODE_HI   = 10;
   localparam int NP_CODE_LO   = 0;
   localparam logic [REG_W-1:0] NP_WR_MASK = 16'hB7FF;
   localparam logic [REG_W-1:0] NP_RESET   = 16'h2001;

endpackage

// ==== hdl/level_sync2.sv ====
// Two-stage synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/100ps
module level_sync2
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_async,
   output logic      o_level
);
   typedef struct packed
   {
      logic meta;
      logic sync;
   } sync_state_t;

   sync_state_t state_q;
   sync_state_t state_d;

   always_comb
   begin
      state_d      = state_q;
      state_d.meta = i_async;
      state_d.sync = state_q.meta;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign o_level = state_q.sync;
endmodule

// ==== hdl/sticky_flag.sv ====
// Latched-high status flag: set by an event, cleared on request, set wins.
`timescale 1ns/100ps
module sticky_flag
(
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_set,
   input  wire logic i_clear,
   output logic      o_flag
);
   typedef struct packed
   {
      logic flag;
   } flag_state_t;

   flag_state_t state_q;
   flag_state_t state_d;

   always_comb
   begin
      state_d      = state_q;
      state_d.flag = i_set | (state_q.flag & ~i_clear);
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign o_flag = state_q.flag;
endmodule

// ==== verif/lp_arbiter_model.sv ====
// Behavioural arbiter and link partner that feed code words and negotiation events to the registers.
`timescale 1ns/100ps
module lp_arbiter_model
(
   input  wire logic        i_clk,
   output logic             o_lcw_valid,
   output logic             o_lcw_base,
   output logic [15:0]      o_lcw_word,
   output logic             o_np_sent,
   output logic             o_an_restart,
   output logic             o_pd_fault
);
   initial
   begin
      o_lcw_valid  = 1'b0;
      o_lcw_base   = 1'b0;
      o_lcw_word   = 16'h5A5A;
      o_np_sent    = 1'b0;
      o_an_restart = 1'b0;
      o_pd_fault   = 1'b0;
   end

   // Outside a strobe the word lines show the inverse of the last word, so a stale value cannot pass.
   task automatic send_page(input logic base, input logic [15:0] word);
      @(posedge i_clk);
      o_lcw_valid <= 1'b1;
      o_lcw_base  <= base;
      o_lcw_word  <= word;
      @(posedge i_clk);
      o_lcw_valid <= 1'b0;
      o_lcw_base  <= ~base;
      o_lcw_word  <= ~word;
   endtask

   task automatic np_exchange();
      @(posedge i_clk);
      o_np_sent <= 1'b1;
      @(posedge i_clk);
      o_np_sent <= 1'b0;
   endtask

   task automatic restart();
      @(posedge i_clk);
      o_an_restart <= 1'b1;
      @(posedge i_clk);
      o_an_restart <= 1'b0;
   endtask

   // The fault level is held long enough to cross the two synchroniser stages.
   task automatic fault(input int cycles);
      @(posedge i_clk);
      o_pd_fault <= 1'b1;
      repeat (cycles) @(posedge i_clk);
      o_pd_fault <= 1'b0;
      repeat (4) @(posedge i_clk);
   endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the partner ability, expansion status and local next-page registers.
`timescale 1ns/100ps
module tb;
   localparam logic [15:0] PAT [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h0C00, 16'h03E0, 16'h001F, 16'hFFFF};

   logic        i_clk;
   logic        i_rst_n;
   logic [4:0]  i_address;
   logic        i_read;
   logic        i_write;
   logic [31:0] i_writedata;
   logic [3:0]  i_byteenable;
   logic [31:0] o_readdata;
   logic        o_waitrequest;
   logic        lcw_valid;
   logic        lcw_base;
   logic [15:0] lcw_word;
   logic        np_sent;
   logic        an_restart;
   logic        pd_fault;
   logic [15:0] o_local_next_page;
   int          err_total;
   int          total_checks;

   always #2 i_clk = ~i_clk;

   autoneg_partner_nextpage_regs DUT
   (
      .i_clk             (i_clk),
      .i_rst_n           (i_rst_n),
      .i_address         (i_address),
      .i_read            (i_read),
      .i_write           (i_write),
      .i_writedata       (i_writedata),
      .i_byteenable      (i_byteenable),
      .o_readdata        (o_readdata),
      .o_waitrequest     (o_waitrequest),
      .i_lcw_valid       (lcw_valid),
      .i_lcw_base        (lcw_base),
      .i_lcw_word        (lcw_word),
      .i_np_sent         (np_sent),
      .i_an_restart      (an_restart),
      .i_pd_fault_async  (pd_fault),
      .o_local_next_page (o_local_next_page)
   );

   lp_arbiter_model lp
   (
      .i_clk        (i_clk),
      .o_lcw_valid  (lcw_valid),
      .o_lcw_base   (lcw_base),
      .o_lcw_word   (lcw_word),
      .o_np_sent    (np_sent),
      .o_an_restart (an_restart),
      .o_pd_fault   (pd_fault)
   );

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // The request is held until waitrequest is sampled low; the bound only guards against a hang.
   task automatic bus(input logic wr, input logic [4:0] addr, input logic [15:0] wd, input logic [3:0] be,
                      output logic [15:0] rd);
      int n;
      @(posedge i_clk);
      i_read       <= ~wr;
      i_write      <= wr;
      i_address    <= addr;
      i_writedata  <= {16'h0000, wd};
      i_byteenable <= be;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_waitrequest !== 1'b0 && n < 20);
      rd = o_readdata[15:0];
      i_read  <= 1'b0;
      i_write <= 1'b0;
      if (o_waitrequest !== 1'b0)
      begin
         err_total++;
         $display("MISMATCH t=%0t bus answer timed out", $time);
         print_verdict();
      end
   endtask

   task automatic rd_chk(input logic [4:0] addr, input logic [15:0] exp);
      logic [15:0] d;
      bus(1'b0, addr, 16'h0000, 4'h0, d);
      check(d, exp);
   endtask

   task automatic wr(input logic [4:0] addr, input logic [15:0] data, input logic [3:0] be);
      logic [15:0] d;
      bus(1'b1, addr, data, be, d);
   endtask

   initial
   begin
      i_clk        = 1'b0;
      i_rst_n      = 1'b0;
      i_address    = 5'h00;
      i_read       = 1'b0;
      i_write      = 1'b0;
      i_writedata  = 32'h0000_0000;
      i_byteenable = 4'h0;
      err_total    = 0;
      total_checks = 0;
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;

      rd_chk(5'h14, 16'h0000);
      rd_chk(5'h18, 16'h0004);
      rd_chk(5'h1C, 16'h2001);
      check(o_local_next_page, 16'h2001);
      $display("test reset_values done");

      for (int k = 0; k < 7; k++)
      begin
         lp.send_page(1'b1, PAT[k]);
         rd_chk(5'h14, PAT[k] & 16'hEFFF);
         rd_chk(5'h18, {12'h000, PAT[k][15], 3'b111});
         rd_chk(5'h18, {12'h000, PAT[k][15], 3'b101});
      end
      $display("test base_pages done");

      lp.send_page(1'b0, 16'h1234);
      rd_chk(5'h14, 16'hEFFF);
      rd_chk(5'h18, 16'h000F);
      wr(5'h14, 16'h0000, 4'hF);
      rd_chk(5'h14, 16'hEFFF);
      wr(5'h18, 16'hFFFF, 4'hF);
      rd_chk(5'h18, 16'h000D);
      rd_chk(5'h00, 16'h0000);
      rd_chk(5'h0C, 16'h0000);
      lp.restart();
      rd_chk(5'h14, 16'h0000);
      rd_chk(5'h18, 16'h0004);
      $display("test read_only_and_restart done");

      wr(5'h1C, 16'hFFFF, 4'h3);
      rd_chk(5'h1C, 16'hB7FF);
      check(o_local_next_page, 16'hB7FF);
      wr(5'h1C, 16'h0000, 4'h1);
      rd_chk(5'h1C, 16'hB700);
      wr(5'h1C, 16'h0000, 4'h2);
      rd_chk(5'h1C, 16'h0000);
      lp.np_exchange();
      rd_chk(5'h1C, 16'h0800);
      check(o_local_next_page, 16'h0800);
      lp.np_exchange();
      rd_chk(5'h1C, 16'h0000);
      lp.np_exchange();
      lp.restart();
      rd_chk(5'h1C, 16'h0000);
      $display("test next_page done");

      lp.fault(6);
      rd_chk(5'h18, 16'h0014);
      rd_chk(5'h18, 16'h0004);
      $display("test parallel_fault done");

      lp.send_page(1'b1, 16'h8001);
      @(posedge i_clk);
      i_rst_n <= 1'b0;
      @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd_chk(5'h18, 16'h0004);
      rd_chk(5'h14, 16'h0000);
      rd_chk(5'h1C, 16'h2001);
      $display("test mid_run_reset done");

      print_verdict();
   end
endmodule
